// ===== common/fp_status_exception_pkg.sv
// Constants for the floating-point status and exception block.
// Assumes 32-bit special registers numbered with bit 31 as the most significant bit.
package fp_status_exception_pkg;

    // ****************************************
    // Special register numbers
    // ****************************************
    localparam logic [9:0] SPR_FP_STATUS_CONTROL = 10'h200;
    localparam logic [9:0] SPR_UNAVAILABLE_VECTOR_OFFSET = 10'h210;
    localparam logic [9:0] SPR_DATA_ERROR_VECTOR_OFFSET = 10'h211;
    localparam logic [9:0] SPR_ROUND_VECTOR_OFFSET = 10'h212;

    // ****************************************
    // Status/control field positions
    // ****************************************
    localparam int BIT_HIGH_GUARD_CAPTURE = 29;
    localparam int BIT_HIGH_STICKY_CAPTURE = 28;
    localparam int BIT_HIGH_INVALID_FLAG = 27;
    localparam int BIT_HIGH_DIVZERO_FLAG = 26;
    localparam int BIT_HIGH_UNDERFLOW_FLAG = 25;
    localparam int BIT_HIGH_OVERFLOW_FLAG = 24;
    localparam int BIT_INEXACT_STICKY = 21;
    localparam int BIT_INVALID_STICKY = 20;
    localparam int BIT_DIVZERO_STICKY = 19;
    localparam int BIT_UNDERFLOW_STICKY = 18;
    localparam int BIT_OVERFLOW_STICKY = 17;
    localparam int BIT_MODE = 16;
    localparam int BIT_LOW_GUARD_CAPTURE = 13;
    localparam int BIT_LOW_STICKY_CAPTURE = 12;
    localparam int BIT_LOW_INVALID_FLAG = 11;
    localparam int BIT_LOW_DIVZERO_FLAG = 10;
    localparam int BIT_LOW_UNDERFLOW_FLAG = 9;
    localparam int BIT_LOW_OVERFLOW_FLAG = 8;
    localparam int BIT_INEXACT_ENABLE = 6;
    localparam int BIT_INVALID_ENABLE = 5;
    localparam int BIT_DIVZERO_ENABLE = 4;
    localparam int BIT_UNDERFLOW_ENABLE = 3;
    localparam int BIT_OVERFLOW_ENABLE = 2;
    localparam int BIT_ROUNDING_MSB = 1;
    localparam int BIT_ROUNDING_LSB = 0;

    localparam logic [31:0] FSC_WRITE_MASK = 32'h3f3e3f7f;
    localparam logic [31:0] FSC_RESET = 32'h0000_0000;
    localparam logic FSC_MODE_SUPPORTED = 1'b0;

    // ****************************************
    // Machine state and syndrome layout
    // ****************************************
    localparam int BIT_UNIT_AVAILABLE = 25;
    localparam int BIT_PROBLEM_STATE = 14;
    localparam logic [31:0] MSR_KEEP_MASK = 32'h0002_1200;
    localparam logic [31:0] SYNDROME_VECTOR_UNIT = 32'h0000_0080;
    localparam logic [31:0] VECTOR_OFFSET_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        RMODE_NEAREST = 2'h0,
        RMODE_TOWARD_ZERO = 2'h1,
        RMODE_TOWARD_PLUS_INF = 2'h2,
        RMODE_TOWARD_MINUS_INF = 2'h3
    } rounding_mode_t;

    typedef enum {
        CAUSE_NONE,
        CAUSE_UNAVAILABLE,
        CAUSE_DATA_ERROR,
        CAUSE_ROUND
    } exc_cause_t;

endpackage

// ===== hdl/fp_status_exception_unit.sv
// Status/control, sticky flags and exception sequencing for the fp vector unit.
// Assumes every input comes from core logic on clk_sys; instr_valid pulses once
// per completing floating-point instruction, with its operands and result status.
//
// Summary of operation
// - Inexact sticky sets on inexact, or masked overflow/underflow, without data exception.
// - Sticky summaries stay set until software writes the status/control register.
// - Invalid, divzero, underflow, overflow stickies follow any matching element flag.
// - Only mode 0 exists; the mode bit always reads back as zero.
// - Low guard/sticky captures track low result, zeroed on data exception.
// - Low invalid flag sets on special low operands or zero over zero.
// - Low divzero flag sets on zero divisor with finite non-zero dividend.
// - Low underflow and overflow flags follow the low element result.
// - Inexact enable turns round conditions into a round exception.
// - Enabled invalid, divzero, underflow or overflow flags give a data exception.
// - Two-bit rounding control selects nearest, zero, plus or minus infinity.
// - Vector instruction with unit-available bit clear takes unavailable exception.
// - Every exception leaves only the vector-unit syndrome bit set.
// - Three privileged vector offset registers sit at special registers 528-530.
// - Unavailable/data exceptions suppress and save faulting address and state.
// - Exceptions keep critical, machine-check, debug enables and clear other state.
// - Handler address is prefix high half, offset bits 15:4, four zeros.
// - Data exception sets cause flags and clears all four capture bits.
// - Round exception truncates inexact elements; exact element captures read zero.
// - Guard is the bit below result lsb; sticky ORs all below.
// - Round exception saves next address, loads captures, sets inexact sticky.
// - Priority unavailable, then data, then round; either element counts.
// - High flags follow the high result; scalar instructions clear them.
// - Status/control register is special register 512.
`timescale 1ns/1ps

module fp_status_exception_unit
    import fp_status_exception_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    // Special register moves
    input wire logic spr_wr_en,
    input wire logic spr_rd_en,
    input wire logic [9:0] spr_num,
    input wire logic [31:0] spr_wdata,
    output logic [31:0] spr_rdata,
    output logic spr_rd_valid,
    // Completing instruction
    input wire logic instr_valid,
    input wire logic instr_is_vector,
    input wire logic instr_is_divide,
    input wire logic [31:0] instr_addr,
    input wire logic [31:0] next_instr_addr,
    input wire logic [31:0] high_op_a,
    input wire logic [31:0] high_op_b,
    input wire logic [31:0] low_op_a,
    input wire logic [31:0] low_op_b,
    input wire logic high_result_overflow,
    input wire logic high_result_underflow,
    input wire logic high_result_guard,
    input wire logic high_result_sticky,
    input wire logic low_result_overflow,
    input wire logic low_result_underflow,
    input wire logic low_result_guard,
    input wire logic low_result_sticky,
    // Core state
    input wire logic [31:0] machine_state,
    input wire logic [31:0] vector_prefix,
    // Towards datapath and pipeline
    output logic suppress_instr,
    output logic truncate_high,
    output logic truncate_low,
    output rounding_mode_t rounding_control,
    output logic mode_bit,
    // Exception results
    output logic exc_valid,
    output exc_cause_t exc_cause,
    output logic [31:0] handler_addr,
    output logic [31:0] save_restore_address,
    output logic [31:0] save_restore_state,
    output logic [31:0] machine_state_next,
    output logic [31:0] syndrome_register
);

    // ****************************************
    // Registers
    // ****************************************
    logic [31:0] fsc_reg, fsc_next;
    logic [31:0] unavailable_vector_offset_reg;
    logic [31:0] data_error_vector_offset_reg;
    logic [31:0] round_vector_offset_reg;
    logic [31:0] spr_rdata_reg;
    logic spr_rd_valid_reg;
    logic exc_valid_reg;
    exc_cause_t exc_cause_reg;
    logic [31:0] handler_addr_reg;
    logic [31:0] save_restore_address_reg;
    logic [31:0] save_restore_state_reg;
    logic [31:0] machine_state_next_reg;
    logic [31:0] syndrome_reg;

    // ****************************************
    // Operand classification
    // ****************************************
    function automatic logic is_special(input logic [31:0] x);
        is_special = (x[30:23] == 8'hff) || (x[30:23] == 8'h00 && x[22:0] != 23'h0);
    endfunction

    function automatic logic is_zero(input logic [31:0] x);
        is_zero = (x[30:0] == 31'h0);
    endfunction

    logic priv_ok, fsc_write;
    logic unavail_exc, exec_ok;
    logic hi_inv, hi_dbz, hi_unf, hi_ovf, hi_inx;
    logic lo_inv, lo_dbz, lo_unf, lo_ovf, lo_inx;
    logic data_cond, round_cond, data_exc, round_exc;
    logic [31:0] fsc_eff;

    // Offset registers are privileged: problem state may not touch them
    assign priv_ok = !machine_state[BIT_PROBLEM_STATE];
    assign fsc_write = spr_wr_en && spr_num == SPR_FP_STATUS_CONTROL;

    // Enables as the instruction sees them, after any same-cycle move
    assign fsc_eff = fsc_write ? (spr_wdata & FSC_WRITE_MASK) : fsc_reg;

    assign unavail_exc = instr_valid && instr_is_vector
        && !machine_state[BIT_UNIT_AVAILABLE];
    assign exec_ok = instr_valid && !unavail_exc;

    // Mode 0 input checks, only mode supported
    assign lo_inv = is_special(low_op_a) || is_special(low_op_b)
        || (instr_is_divide && is_zero(low_op_a) && is_zero(low_op_b));
    assign lo_dbz = instr_is_divide && is_zero(low_op_b) && !is_zero(low_op_a)
        && low_op_a[30:23] != 8'hff;
    assign lo_unf = low_result_underflow;
    assign lo_ovf = low_result_overflow;
    assign lo_inx = low_result_guard || low_result_sticky;

    // Scalar instructions leave the high element untouched and its flags clear
    assign hi_inv = instr_is_vector && (is_special(high_op_a) || is_special(high_op_b)
        || (instr_is_divide && is_zero(high_op_a) && is_zero(high_op_b)));
    assign hi_dbz = instr_is_vector && instr_is_divide && is_zero(high_op_b)
        && !is_zero(high_op_a) && high_op_a[30:23] != 8'hff;
    assign hi_unf = instr_is_vector && high_result_underflow;
    assign hi_ovf = instr_is_vector && high_result_overflow;
    assign hi_inx = instr_is_vector && (high_result_guard || high_result_sticky);

    assign data_cond = (fsc_eff[BIT_INVALID_ENABLE] && (hi_inv || lo_inv))
        || (fsc_eff[BIT_DIVZERO_ENABLE] && (hi_dbz || lo_dbz))
        || (fsc_eff[BIT_UNDERFLOW_ENABLE] && (hi_unf || lo_unf))
        || (fsc_eff[BIT_OVERFLOW_ENABLE] && (hi_ovf || lo_ovf));

    // Either element counts; round needs no data exception on either
    assign round_cond = !data_cond && (
        ((hi_inx || lo_inx) && !(hi_ovf || lo_ovf || hi_unf || lo_unf))
        || ((hi_ovf || lo_ovf) && !fsc_eff[BIT_OVERFLOW_ENABLE])
        || ((hi_unf || lo_unf) && !fsc_eff[BIT_UNDERFLOW_ENABLE]));

    assign data_exc = exec_ok && data_cond;
    assign round_exc = exec_ok && round_cond && fsc_eff[BIT_INEXACT_ENABLE];

    // Faulting instruction must not write its target
    assign suppress_instr = unavail_exc || data_exc;
    // Inexact elements get the truncated result, exact one the rounded
    assign truncate_high = round_exc && hi_inx;
    assign truncate_low = round_exc && lo_inx;

    // ****************************************
    // Status/control register
    // ****************************************
    always_comb begin
        fsc_next = fsc_reg;
        if (fsc_write) begin
            fsc_next = spr_wdata & FSC_WRITE_MASK;
        end
        fsc_next[BIT_MODE] = FSC_MODE_SUPPORTED;
        if (exec_ok) begin
            fsc_next[BIT_HIGH_INVALID_FLAG] = hi_inv;
            fsc_next[BIT_HIGH_DIVZERO_FLAG] = hi_dbz;
            fsc_next[BIT_HIGH_UNDERFLOW_FLAG] = hi_unf;
            fsc_next[BIT_HIGH_OVERFLOW_FLAG] = hi_ovf;
            fsc_next[BIT_LOW_INVALID_FLAG] = lo_inv;
            fsc_next[BIT_LOW_DIVZERO_FLAG] = lo_dbz;
            fsc_next[BIT_LOW_UNDERFLOW_FLAG] = lo_unf;
            fsc_next[BIT_LOW_OVERFLOW_FLAG] = lo_ovf;
            // Captures only survive when no data exception is taken
            fsc_next[BIT_HIGH_GUARD_CAPTURE] = !data_cond && instr_is_vector
                && high_result_guard;
            fsc_next[BIT_HIGH_STICKY_CAPTURE] = !data_cond && instr_is_vector
                && high_result_sticky;
            fsc_next[BIT_LOW_GUARD_CAPTURE] = !data_cond && low_result_guard;
            fsc_next[BIT_LOW_STICKY_CAPTURE] = !data_cond && low_result_sticky;
            // Set wins over a same-cycle software clear
            fsc_next[BIT_INVALID_STICKY] = fsc_next[BIT_INVALID_STICKY]
                || hi_inv || lo_inv;
            fsc_next[BIT_DIVZERO_STICKY] = fsc_next[BIT_DIVZERO_STICKY]
                || hi_dbz || lo_dbz;
            fsc_next[BIT_UNDERFLOW_STICKY] = fsc_next[BIT_UNDERFLOW_STICKY]
                || hi_unf || lo_unf;
            fsc_next[BIT_OVERFLOW_STICKY] = fsc_next[BIT_OVERFLOW_STICKY]
                || hi_ovf || lo_ovf;
            fsc_next[BIT_INEXACT_STICKY] = fsc_next[BIT_INEXACT_STICKY]
                || round_cond;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            fsc_reg <= FSC_RESET;
        end else begin
            fsc_reg <= fsc_next;
        end
    end

    assign rounding_control =
        rounding_mode_t'(fsc_reg[BIT_ROUNDING_MSB:BIT_ROUNDING_LSB]);
    assign mode_bit = fsc_reg[BIT_MODE];

    // ****************************************
    // Vector offset registers
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            unavailable_vector_offset_reg <= VECTOR_OFFSET_RESET;
            data_error_vector_offset_reg <= VECTOR_OFFSET_RESET;
            round_vector_offset_reg <= VECTOR_OFFSET_RESET;
        end else if (spr_wr_en && priv_ok) begin
            if (spr_num == SPR_UNAVAILABLE_VECTOR_OFFSET) begin
                unavailable_vector_offset_reg <= spr_wdata;
            end
            if (spr_num == SPR_DATA_ERROR_VECTOR_OFFSET) begin
                data_error_vector_offset_reg <= spr_wdata;
            end
            if (spr_num == SPR_ROUND_VECTOR_OFFSET) begin
                round_vector_offset_reg <= spr_wdata;
            end
        end
    end

    // ****************************************
    // Register reads, one cycle after the request
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            spr_rdata_reg <= 32'h0000_0000;
            spr_rd_valid_reg <= 1'b0;
        end else begin
            spr_rd_valid_reg <= spr_rd_en;
            spr_rdata_reg <= 32'h0000_0000;
            if (spr_rd_en) begin
                case (spr_num)
                    SPR_FP_STATUS_CONTROL: spr_rdata_reg <= fsc_reg;
                    SPR_UNAVAILABLE_VECTOR_OFFSET: begin
                        spr_rdata_reg <= priv_ok ? unavailable_vector_offset_reg : 32'h0000_0000;
                    end
                    SPR_DATA_ERROR_VECTOR_OFFSET: begin
                        spr_rdata_reg <= priv_ok ? data_error_vector_offset_reg : 32'h0000_0000;
                    end
                    SPR_ROUND_VECTOR_OFFSET: begin
                        spr_rdata_reg <= priv_ok ? round_vector_offset_reg : 32'h0000_0000;
                    end
                    default: spr_rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign spr_rdata = spr_rdata_reg;
    assign spr_rd_valid = spr_rd_valid_reg;

    // ****************************************
    // Exception sequencing
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            exc_valid_reg <= 1'b0;
            exc_cause_reg <= CAUSE_NONE;
            handler_addr_reg <= 32'h0000_0000;
            save_restore_address_reg <= 32'h0000_0000;
            save_restore_state_reg <= 32'h0000_0000;
            machine_state_next_reg <= 32'h0000_0000;
            syndrome_reg <= 32'h0000_0000;
        end else begin
            exc_valid_reg <= unavail_exc || data_exc || round_exc;
            if (unavail_exc || data_exc || round_exc) begin
                save_restore_state_reg <= machine_state;
                machine_state_next_reg <= machine_state & MSR_KEEP_MASK;
                syndrome_reg <= SYNDROME_VECTOR_UNIT;
            end
            if (unavail_exc) begin
                exc_cause_reg <= CAUSE_UNAVAILABLE;
                save_restore_address_reg <= instr_addr;
                handler_addr_reg <= {vector_prefix[31:16],
                    unavailable_vector_offset_reg[15:4], 4'h0};
            end else if (data_exc) begin
                exc_cause_reg <= CAUSE_DATA_ERROR;
                save_restore_address_reg <= instr_addr;
                handler_addr_reg <= {vector_prefix[31:16],
                    data_error_vector_offset_reg[15:4], 4'h0};
            end else if (round_exc) begin
                exc_cause_reg <= CAUSE_ROUND;
                save_restore_address_reg <= next_instr_addr;
                handler_addr_reg <= {vector_prefix[31:16],
                    round_vector_offset_reg[15:4], 4'h0};
            end
        end
    end

    assign exc_valid = exc_valid_reg;
    assign exc_cause = exc_cause_reg;
    assign handler_addr = handler_addr_reg;
    assign save_restore_address = save_restore_address_reg;
    assign save_restore_state = save_restore_state_reg;
    assign machine_state_next = machine_state_next_reg;
    assign syndrome_register = syndrome_reg;

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_unavail_attempt;
        instr_valid && instr_is_vector && !machine_state[BIT_UNIT_AVAILABLE];
    endsequence

    sequence s_unavail_taken;
        exc_valid && exc_cause == CAUSE_UNAVAILABLE
            && handler_addr == {$past(vector_prefix[31:16]),
                $past(unavailable_vector_offset_reg[15:4]), 4'h0};
    endsequence

    property p_unavail_vector;
        @(posedge clk_sys) disable iff (!reset_n)
        s_unavail_attempt |-> suppress_instr ##1 s_unavail_taken;
    endproperty
    a_unavail_vector: assert property (p_unavail_vector) else $error("no unavailable");

    property p_sticky_hold;
        @(posedge clk_sys) disable iff (!reset_n)
        fsc_reg[BIT_OVERFLOW_STICKY] && !fsc_write |=> fsc_reg[BIT_OVERFLOW_STICKY];
    endproperty
    a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag lost");

    property p_mode_readback;
        @(posedge clk_sys) disable iff (!reset_n)
        fsc_write |=> !fsc_reg[BIT_MODE] && fsc_reg[31:30] == 2'h0 && fsc_reg[7] == 1'b0;
    endproperty
    a_mode_readback: assert property (p_mode_readback) else $error("bad readback");

    property p_data_clears_capture;
        @(posedge clk_sys) disable iff (!reset_n)
        data_exc |=> fsc_reg[BIT_HIGH_GUARD_CAPTURE:BIT_HIGH_STICKY_CAPTURE] == 2'h0
            && fsc_reg[BIT_LOW_GUARD_CAPTURE:BIT_LOW_STICKY_CAPTURE] == 2'h0
            && exc_cause == CAUSE_DATA_ERROR;
    endproperty
    a_data_clears_capture: assert property (p_data_clears_capture)
        else $error("capture not cleared");

    property p_priority;
        @(posedge clk_sys) disable iff (!reset_n)
        exc_valid && exc_cause == CAUSE_ROUND |-> !$past(data_cond) && !$past(unavail_exc);
    endproperty
    a_priority: assert property (p_priority) else $error("round over higher priority");

    property p_syndrome_state;
        @(posedge clk_sys) disable iff (!reset_n)
        exc_valid |-> syndrome_register == SYNDROME_VECTOR_UNIT
            && machine_state_next == ($past(machine_state) & MSR_KEEP_MASK)
            && save_restore_state == $past(machine_state);
    endproperty
    a_syndrome_state: assert property (p_syndrome_state) else $error("bad exc state");

    sequence s_round_taken;
        round_exc ##1 exc_valid && exc_cause == CAUSE_ROUND;
    endsequence

    property p_round_saves_next;
        @(posedge clk_sys) disable iff (!reset_n)
        s_round_taken |-> save_restore_address == $past(next_instr_addr)
            && fsc_reg[BIT_INEXACT_STICKY];
    endproperty
    a_round_saves_next: assert property (p_round_saves_next) else $error("bad save");

    property p_inexact_sticky;
        @(posedge clk_sys) disable iff (!reset_n)
        exec_ok && round_cond |=> fsc_reg[BIT_INEXACT_STICKY]
            ##1 (fsc_reg[BIT_INEXACT_STICKY] || $past(fsc_write));
    endproperty
    a_inexact_sticky: assert property (p_inexact_sticky) else $error("inexact lost");

    property p_low_divzero;
        @(posedge clk_sys) disable iff (!reset_n)
        exec_ok && lo_dbz |=> fsc_reg[BIT_LOW_DIVZERO_FLAG] && fsc_reg[BIT_DIVZERO_STICKY];
    endproperty
    a_low_divzero: assert property (p_low_divzero) else $error("divzero flag missing");

endmodule

// ===== sim/core_model.sv
// Core-side partner: holds the machine state seen by the unit.
// Assumes the bench preloads the state before each instruction.
`timescale 1ns/1ps
module core_model(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic load_en,
    input wire logic [31:0] load_val,
    input wire logic exc_valid,
    input wire logic [31:0] machine_state_next,
    output logic [31:0] machine_state
);
    // Takes the cleared state on exception, as the real sequencer would
    always_ff @(posedge clk_sys) begin
        if (!reset_n) machine_state <= '0;
        else if (load_en) machine_state <= load_val;
        else if (exc_valid) machine_state <= machine_state_next;
    end
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the fp status and exception unit.
// Assumes fixed latencies: read data one cycle, exception one cycle after issue.
`timescale 1ns/1ps
module tb_top;
    import fp_status_exception_pkg::*;
    logic clk_sys = 0, reset_n = 0, load_en = 0, spr_wr_en = 0, spr_rd_en = 0;
    logic instr_valid = 0, instr_is_vector = 0, instr_is_divide = 0;
    logic high_result_overflow = 0, high_result_underflow = 0, high_result_guard = 0;
    logic high_result_sticky = 0, low_result_overflow = 0, low_result_underflow = 0;
    logic low_result_guard = 0, low_result_sticky = 0, spr_rd_valid, suppress_instr;
    logic truncate_high, truncate_low, mode_bit, exc_valid;
    logic [9:0] spr_num = '0;
    logic [31:0] spr_wdata = '0, instr_addr = '0, next_instr_addr = '0, vector_prefix = '0;
    logic [31:0] high_op_a = '0, high_op_b = '0, low_op_a = '0, low_op_b = '0, load_val = '0;
    logic [31:0] spr_rdata, handler_addr, save_restore_address, save_restore_state;
    logic [31:0] machine_state_next, syndrome_register, machine_state, fsc = '0;
    logic [31:0] off [3];
    rounding_mode_t rounding_control;
    exc_cause_t exc_cause;
    int fails = 0, n_checks = 0, seed = 32'h6748;
    fp_status_exception_unit DUT (.*);
    core_model partner (.*);
    always #5 clk_sys = ~clk_sys;
    // ****************************************
    // Checking helpers and reference model
    // ****************************************
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    function automatic bit spc(logic [31:0] x);
        return x[30:23] == 8'hff || (x[30:23] == 8'h00 && x[22:0] != 23'h0);
    endfunction
    function automatic bit zr(logic [31:0] x);
        return x[30:0] == 31'h0;
    endfunction
    function automatic logic [31:0] pick();
        case ($random(seed) & 3)
            0: return 32'h0;
            1: return 32'h7f800000;
            2: return 32'h3f800000;
            default: return $random(seed);
        endcase
    endfunction
    task automatic spr(bit w, logic [9:0] n, logic [31:0] d);
        @(posedge clk_sys);
        spr_wr_en <= w;
        spr_rd_en <= !w;
        spr_num <= n;
        spr_wdata <= d;
        @(posedge clk_sys);
        spr_wr_en <= 0;
        spr_rd_en <= 0;
        #1;
        if (w && n == SPR_FP_STATUS_CONTROL) fsc = d & FSC_WRITE_MASK;
        if (!w) chk("rdata", d, spr_rdata);
        chk("rd_valid", !w, spr_rd_valid);
    endtask
    // Stat bits: ho hu hg hs lo lu lg ls
    task automatic ins(logic [31:0] ms, la, lb, ha, hb, logic [7:0] st, bit v, bit d);
        logic [3:0] lf, hf, f, en;
        logic [7:0] sd;
        bit dat, cnd, rnd;
        logic [31:0] ia;
        exc_cause_t c;
        ia = $random(seed) & 32'hffff_fffc;
        sd = st;
        if (!v) st[7:4] = 4'h0;
        lf = {spc(la) || spc(lb) || (d && zr(la) && zr(lb)),
              d && zr(lb) && !zr(la) && la[30:23] != 8'hff, st[2], st[3]};
        hf = v ? {spc(ha) || spc(hb) || (d && zr(ha) && zr(hb)),
                  d && zr(hb) && !zr(ha) && ha[30:23] != 8'hff, st[6], st[7]} : 4'h0;
        f = lf | hf;
        en = fsc[5:2];
        dat = |(f & en);
        cnd = (|{st[5:4], st[1:0]} && !f[1] && !f[0]) || (f[0] && !en[0]) || (f[1] && !en[1]);
        rnd = cnd && !dat && fsc[BIT_INEXACT_ENABLE];
        c = (v && !ms[BIT_UNIT_AVAILABLE]) ? CAUSE_UNAVAILABLE : dat ? CAUSE_DATA_ERROR :
            rnd ? CAUSE_ROUND : CAUSE_NONE;
        rnd = (c == CAUSE_ROUND);
        @(posedge clk_sys);
        load_en <= 1;
        load_val <= ms;
        @(posedge clk_sys);
        load_en <= 0;
        {instr_valid, instr_is_vector, instr_is_divide} <= {1'b1, v, d};
        {instr_addr, next_instr_addr, vector_prefix} <= {ia, ia + 32'h4, $random(seed)};
        {low_op_a, low_op_b, high_op_a, high_op_b} <= {la, lb, ha, hb};
        {high_result_overflow, high_result_underflow, high_result_guard} <= sd[7:5];
        {high_result_sticky, low_result_overflow, low_result_underflow} <= {sd[4], st[3:2]};
        {low_result_guard, low_result_sticky} <= st[1:0];
        #1;
        chk("suppress", c inside {CAUSE_UNAVAILABLE, CAUSE_DATA_ERROR}, suppress_instr);
        chk("trunc", {rnd && |st[5:4], rnd && |st[1:0]}, {truncate_high, truncate_low});
        if (c != CAUSE_UNAVAILABLE) begin
            fsc[29:24] = {dat ? 2'b00 : st[5:4], hf};
            fsc[13:8] = {dat ? 2'b00 : st[1:0], lf};
            fsc[21:17] = fsc[21:17] | {cnd && !dat, f};
        end
        @(posedge clk_sys);
        instr_valid <= 0;
        #1;
        chk("exc_valid", c != CAUSE_NONE, exc_valid);
        if (c != CAUSE_NONE) begin
            chk("cause", c, exc_cause);
            chk("handler", {vector_prefix[31:16], off[c - 1][15:4], 4'h0}, handler_addr);
            chk("save_restore_address", c == CAUSE_ROUND ? ia + 32'h4 : ia, save_restore_address);
            chk("save_restore_state", ms, save_restore_state);
            chk("msr", ms & MSR_KEEP_MASK, machine_state_next);
            chk("esr", SYNDROME_VECTOR_UNIT, syndrome_register);
        end
        spr(0, SPR_FP_STATUS_CONTROL, fsc);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1;
        spr(0, SPR_FP_STATUS_CONTROL, 32'h0);
        spr(1, SPR_FP_STATUS_CONTROL, 32'hffff_ffff);
        spr(0, SPR_FP_STATUS_CONTROL, FSC_WRITE_MASK);
        for (int i = 0; i < 4; i++) begin
            spr(1, SPR_FP_STATUS_CONTROL, i);
            chk("rmode", {i[1:0], 1'b0}, {rounding_control, mode_bit});
        end
        for (int i = 0; i < 3; i++) begin
            off[i] = $random(seed) & 32'h0000_fff0;
            spr(1, SPR_UNAVAILABLE_VECTOR_OFFSET + 10'(i), off[i]);
            spr(0, SPR_UNAVAILABLE_VECTOR_OFFSET + 10'(i), off[i]);
        end
        spr(1, SPR_FP_STATUS_CONTROL, 32'h0000_0074);
        ins(32'h0, 0, 0, 0, 0, 8'h0, 1, 0);
        ins(32'h0200_3200, 32'h7f800000, 0, 0, 0, 8'h0, 1, 0);
        ins(32'h0200_0000, 32'h3f800000, 0, 0, 0, 8'h0, 0, 1);
        ins(32'h0200_0000, 0, 0, 0, 0, 8'h23, 1, 0);
        ins(32'h0000_4000, 0, 0, 0, 0, 8'h0, 0, 0);
        spr(1, SPR_ROUND_VECTOR_OFFSET, 32'h0000_fff0);
        spr(0, SPR_ROUND_VECTOR_OFFSET, 32'h0);
        for (int i = 0; i < 300; i++) begin
            if (($random(seed) & 3) == 0) spr(1, SPR_FP_STATUS_CONTROL, $random(seed));
            ins($random(seed) & 32'hffff_bfff, pick(), pick(), pick(), pick(),
                8'($random(seed)), 1'($random(seed)), 1'($random(seed)));
        end
        conclude();
    end
    initial begin
        #500_000;
        fails++;
        conclude();
    end
endmodule
